/* File: src/core_status_and_interrupt_dispatch.sv */
`timescale 1ns/1ps
`default_nettype none
module core_status_and_interrupt_dispatch
  import core_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            srst_in,
  // Avalon-MM slave
  input  wire logic [10:0]     avs_address_in,
  input  wire logic            avs_read_in,
  input  wire logic            avs_write_in,
  input  wire logic [31:0]     avs_writedata_in,
  input  wire logic [3:0]      avs_byteenable_in,
  output logic      [31:0]     avs_readdata_out,
  output logic                 avs_waitrequest_out,
  // Instruction sequencer
  input  wire logic            instr_done_in,
  input  wire logic            instr_multi_in,
  input  wire logic            return_from_interrupt_in,
  input  wire logic            push_in,
  input  wire logic            pop_in,
  input  wire alu_req_type     alu_in,
  // Interrupt sources
  input  wire logic [15:0]     irq_event_in,
  // Core-facing outputs
  output call_type             call_out,
  output stack_write_type      stack_write_out,
  output logic      [15:0]     indirect_pointer_out,
  output logic      [7:0]      bank_base_out,
  output logic      [7:0]      status_word_out
);

  typedef struct packed {
    logic               wait_n;
    logic [31:0]        rdata;
    logic [7:0]         stack_top;
    logic [7:0]         ptr_low;
    logic [7:0]         ptr_high;
    status_word_type    status_word;
    logic [7:0]         accum;
    logic [7:0]         second_acc;
    logic [7:0]         enable_one;
    logic [7:0]         prio_one;
    logic [7:0]         ext_enable_one;
    logic [7:0]         ext_enable_two;
    logic [7:0]         ext_prio_one;
    logic [7:0]         ext_prio_two;
    logic [15:0]        pending;
    logic [15:0]        detect;
    logic               ea_seen;
    dispatch_state_type st;
    logic [2:0]         cnt;
    call_type           call;
    stack_write_type    stack_wr;
    logic               svc_low;
    logic               svc_high;
    logic [7:0]         bank_base;
  } state_type;

  state_type q;
  state_type d;

  logic [8:0]  idx;
  logic        bus_req;
  logic        bus_wr;
  logic [7:0]  wbyte;
  logic [15:0] en_vec;
  logic [15:0] pr_vec;
  logic [15:0] hi_req;
  logic [15:0] lo_req;
  logic        hi_found;
  logic        lo_found;
  logic [3:0]  hi_idx;
  logic [3:0]  lo_idx;
  logic        sel_found;
  logic [3:0]  sel_idx;
  logic        sel_high;
  logic        take;

  function automatic logic [4:0] first_one(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : first_one

  always_comb begin
    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [15:0] prod;
    logic        cin;
    logic [7:0]  r8;
    logic [15:0] wr_pend;
    d         = q;
    idx       = avs_address_in[10:2];
    bus_req   = avs_read_in | avs_write_in;
    bus_wr    = avs_write_in & q.wait_n & avs_byteenable_in[0]; // Lands on the edge that ends the transfer
    wbyte     = avs_writedata_in[7:0];
    sum9      = 9'h000;
    nib5      = 5'h00;
    prod      = 16'h0000;
    r8        = 8'h00;
    cin       = q.status_word.carry_flag;
    wr_pend   = q.pending;

    // Source map: low enable register covers sources 0-6, extended one 7-14, extended two 15
    en_vec = {q.ext_enable_two[0], q.ext_enable_one, q.enable_one[6:0]};
    pr_vec = {q.ext_prio_two[0], q.ext_prio_one, q.prio_one[6:0]};

    // Sampled every clock; one registered cycle of detection
    d.detect  = q.pending & en_vec & {NUM_SRC{q.enable_one[BIT_GLOBAL]}};
    d.ea_seen = q.enable_one[BIT_GLOBAL];

    hi_req = q.detect & pr_vec;
    lo_req = q.detect & ~pr_vec;
    {hi_found, hi_idx} = first_one(hi_req);
    {lo_found, lo_idx} = first_one(lo_req);
    // High service blocks all; low service admits only high
    sel_high  = hi_found & ~q.svc_high;
    sel_found = sel_high | (lo_found & ~q.svc_low & ~q.svc_high);
    sel_idx   = sel_high ? hi_idx : lo_idx;
    // A detection made before the enable clear still counts if the instruction was single-cycle
    // Never on the boundary of the return itself, so one more instruction runs first
    take = (q.st == ST_RUN) & instr_done_in & ~return_from_interrupt_in & sel_found &
           (q.enable_one[BIT_GLOBAL] | ~instr_multi_in);

    // Avalon answer: one wait state, then data and waitrequest low for one cycle
    d.wait_n = bus_req & ~q.wait_n;
    if (bus_req & ~q.wait_n) begin
      unique case (idx)
        IDX_STACK_TOP:      d.rdata = {24'h000000, q.stack_top};
        IDX_PTR_LOW:        d.rdata = {24'h000000, q.ptr_low};
        IDX_PTR_HIGH:       d.rdata = {24'h000000, q.ptr_high};
        IDX_ENABLE_ONE:     d.rdata = {24'h000000, q.enable_one};
        IDX_PRIO_ONE:       d.rdata = {24'h000000, q.prio_one};
        IDX_STATUS_WORD:    d.rdata = {24'h000000, q.status_word};
        IDX_ACCUM:          d.rdata = {24'h000000, q.accum};
        IDX_EXT_ENABLE_ONE: d.rdata = {24'h000000, q.ext_enable_one};
        IDX_EXT_ENABLE_TWO: d.rdata = {24'h000000, q.ext_enable_two};
        IDX_SECOND_ACC:     d.rdata = {24'h000000, q.second_acc};
        IDX_EXT_PRIO_ONE:   d.rdata = {24'h000000, q.ext_prio_one};
        IDX_EXT_PRIO_TWO:   d.rdata = {24'h000000, q.ext_prio_two};
        IDX_PEND_LOW:       d.rdata = {24'h000000, q.pending[7:0]};
        IDX_PEND_HIGH:      d.rdata = {24'h000000, q.pending[15:8]};
        IDX_SERVICE:        d.rdata = {29'h00000000, q.st == ST_CALL, q.svc_high, q.svc_low};
        default:            d.rdata = 32'h00000000;
      endcase
    end

    // Arithmetic; results land in the accumulators and the status flags
    unique case (alu_in.op)
      ALU_ADD, ALU_ADD_WITH_CARRY: begin
        cin  = (alu_in.op == ALU_ADD_WITH_CARRY) ? q.status_word.carry_flag : 1'b0;
        sum9 = {1'b0, q.accum} + {1'b0, alu_in.operand} + {8'h00, cin};
        nib5 = {1'b0, q.accum[3:0]} + {1'b0, alu_in.operand[3:0]} + {4'h0, cin};
        r8   = sum9[7:0];
        d.accum = r8;
        d.status_word.carry_flag        = sum9[8];
        d.status_word.nibble_carry_flag = nib5[4];
        d.status_word.overflow_flag     = (q.accum[7] == alu_in.operand[7]) & (r8[7] != q.accum[7]);
      end
      ALU_SUBTRACT_WITH_BORROW: begin
        sum9 = {1'b0, q.accum} - {1'b0, alu_in.operand} - {8'h00, cin};
        nib5 = {1'b0, q.accum[3:0]} - {1'b0, alu_in.operand[3:0]} - {4'h0, cin};
        r8   = sum9[7:0];
        d.accum = r8;
        d.status_word.carry_flag        = sum9[8];
        d.status_word.nibble_carry_flag = nib5[4];
        d.status_word.overflow_flag     = (q.accum[7] != alu_in.operand[7]) & (r8[7] != q.accum[7]);
      end
      ALU_MUL: begin
        prod = q.accum * q.second_acc;
        d.accum      = prod[7:0];
        d.second_acc = prod[15:8];
        d.status_word.carry_flag        = 1'b0;
        d.status_word.nibble_carry_flag = 1'b0;
        d.status_word.overflow_flag     = prod[15:8] != 8'h00;
      end
      ALU_DIV: begin
        // Divide by zero leaves both accumulators untouched
        if (q.second_acc != 8'h00) begin
          d.accum      = q.accum / q.second_acc;
          d.second_acc = q.accum % q.second_acc;
        end
        d.status_word.carry_flag        = 1'b0;
        d.status_word.nibble_carry_flag = 1'b0;
        d.status_word.overflow_flag     = q.second_acc == 8'h00;
      end
      default: begin
      end
    endcase

    // Stack: pre-increment on push, return address popped on return
    d.stack_wr.valid = 1'b0;
    if (q.st == ST_RUN) begin
      if (push_in) begin
        d.stack_top      = q.stack_top + 8'h01;
        d.stack_wr.valid = 1'b1;
        d.stack_wr.addr  = q.stack_top + 8'h01;
      end else if (pop_in) begin
        d.stack_top = q.stack_top - 8'h01;
      end
    end
    if (instr_done_in & return_from_interrupt_in & (q.st == ST_RUN)) begin
      d.stack_top = q.stack_top - RETURN_BYTES;
      if (q.svc_high) begin
        d.svc_high = 1'b0;
      end else begin
        d.svc_low = 1'b0;
      end
    end

    // Vectoring call sequence
    unique case (q.st)
      ST_RUN: begin
        if (take) begin
          d.st              = ST_CALL;
          d.cnt             = CALL_CYCLES;
          d.call.busy       = 1'b1;
          d.call.level_high = sel_high;
          d.call.vector     = VEC_BASE + ({12'h000, sel_idx} << VEC_SHIFT);
          if (sel_high) begin
            d.svc_high = 1'b1;
          end else begin
            d.svc_low = 1'b1;
          end
        end
      end
      ST_CALL: begin
        d.cnt = q.cnt - 3'h1;
        if ((q.cnt == CALL_PUSH_A) | (q.cnt == CALL_PUSH_B)) begin
          d.stack_top      = q.stack_top + 8'h01;
          d.stack_wr.valid = 1'b1;
          d.stack_wr.addr  = q.stack_top + 8'h01;
        end
        if (q.cnt == 3'h1) begin
          d.st        = ST_RUN;
          d.call.busy = 1'b0;
        end
      end
    endcase

    // Software writes win over hardware for the plain registers
    if (bus_wr) begin
      unique case (idx)
        IDX_STACK_TOP:      d.stack_top      = wbyte;
        IDX_PTR_LOW:        d.ptr_low        = wbyte;
        IDX_PTR_HIGH:       d.ptr_high       = wbyte;
        IDX_ENABLE_ONE:     d.enable_one     = wbyte;
        IDX_PRIO_ONE:       d.prio_one       = wbyte;
        IDX_STATUS_WORD:    d.status_word    = status_word_type'(wbyte);
        IDX_ACCUM:          d.accum          = wbyte;
        IDX_EXT_ENABLE_ONE: d.ext_enable_one = wbyte;
        IDX_EXT_ENABLE_TWO: d.ext_enable_two = wbyte;
        IDX_SECOND_ACC:     d.second_acc     = wbyte;
        IDX_EXT_PRIO_ONE:   d.ext_prio_one   = wbyte;
        IDX_EXT_PRIO_TWO:   d.ext_prio_two   = wbyte;
        IDX_PEND_LOW:       wr_pend[7:0]     = wbyte;
        IDX_PEND_HIGH:      wr_pend[15:8]    = wbyte;
        default: begin
        end
      endcase
    end

    // Pending flags: software may set or clear, call clears edge sources, events win
    if (take) begin
      wr_pend = wr_pend & ~(AUTO_CLEAR_MASK & (16'h0001 << sel_idx));
    end
    d.pending = wr_pend | irq_event_in;

    // Parity is never stored from software; it follows the next accumulator
    d.status_word.parity_flag = ^d.accum;
    d.bank_base = 8'({6'h00, d.status_word.bank_select} << BANK_SHIFT);

    if (srst_in) begin
      d           = '0;
      d.stack_top = RST_STACK_TOP;
      d.ptr_low   = RST_ZERO;
      d.st        = ST_RUN;
    end
  end

  always_ff @(posedge clk_in) begin
    q <= d;
  end

  assign avs_readdata_out     = q.rdata;
  assign avs_waitrequest_out  = ~q.wait_n;
  assign call_out             = q.call;
  assign stack_write_out      = q.stack_wr;
  assign indirect_pointer_out = {q.ptr_high, q.ptr_low};
  assign bank_base_out        = q.bank_base;
  assign status_word_out      = q.status_word;

  property p_push_preinc;
    @(posedge clk_in) disable iff (srst_in)
      (push_in && q.st == ST_RUN && !(bus_wr && idx == IDX_STACK_TOP))
      |=> (q.stack_top == $past(q.stack_top) + 8'h01) && q.stack_wr.valid && (q.stack_wr.addr == q.stack_top);
  endproperty
  a_push_preinc: assert property (p_push_preinc) else $error("stack top not pre-incremented on push");

  property p_parity;
    @(posedge clk_in) disable iff (srst_in) q.status_word.parity_flag == ^q.accum;
  endproperty
  a_parity: assert property (p_parity) else $error("parity does not follow accumulator");

  property p_carry_add;
    @(posedge clk_in) disable iff (srst_in)
      (alu_in.op == ALU_ADD && !bus_wr) |=>
      q.status_word.carry_flag == ((9'($past(q.accum)) + 9'($past(alu_in.operand))) > 9'h0FF);
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("carry wrong after add");

  property p_mul_ov;
    @(posedge clk_in) disable iff (srst_in)
      (alu_in.op == ALU_MUL && !bus_wr) |=>
      q.status_word.overflow_flag == ((16'($past(q.accum)) * 16'($past(q.second_acc))) > 16'h00FF);
  endproperty
  a_mul_ov: assert property (p_mul_ov) else $error("overflow wrong after multiply");

  property p_global_block;
    @(posedge clk_in) disable iff (srst_in)
      (!q.enable_one[BIT_GLOBAL] && !q.ea_seen) |-> !take;
  endproperty
  a_global_block: assert property (p_global_block) else $error("call taken with global enable off");

  property p_call_length;
    @(posedge clk_in) disable iff (srst_in)
      take |=> q.call.busy [*4] ##1 !q.call.busy;
  endproperty
  a_call_length: assert property (p_call_length) else $error("vectoring call not four cycles");

  property p_vector;
    @(posedge clk_in) disable iff (srst_in)
      take |=> q.call.vector == VEC_BASE + ({12'h000, $past(sel_idx)} << VEC_SHIFT);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector address");

  property p_no_take_on_return;
    @(posedge clk_in) disable iff (srst_in) (instr_done_in && return_from_interrupt_in) |-> !take;
  endproperty
  a_no_take_on_return: assert property (p_no_take_on_return) else $error("re-entry before next instruction");

  property p_high_not_preempted;
    @(posedge clk_in) disable iff (srst_in) q.svc_high |-> !take;
  endproperty
  a_high_not_preempted: assert property (p_high_not_preempted) else $error("high level routine preempted");

  property p_auto_clear;
    @(posedge clk_in) disable iff (srst_in)
      (take && AUTO_CLEAR_MASK[sel_idx] && !irq_event_in[sel_idx] && !bus_wr) |=> !q.pending[$past(sel_idx)];
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("edge source flag not cleared at call");

  property p_bank_base;
    @(posedge clk_in) disable iff (srst_in) bank_base_out == {3'h0, q.status_word.bank_select, 3'h0};
  endproperty
  a_bank_base: assert property (p_bank_base) else $error("bank base mismatch");

  property p_reserved_read;
    @(posedge clk_in) disable iff (srst_in)
      (avs_read_in && avs_waitrequest_out && idx == 9'h0B4) |=> avs_readdata_out == 32'h00000000;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved address read not zero");

endmodule : core_status_and_interrupt_dispatch
`default_nettype wire

/* File: pkg/core_ctrl_pkg.sv */
`default_nettype none
package core_ctrl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_STACK_TOP      = 9'h081;
  localparam logic [8:0] IDX_PTR_LOW        = 9'h082;
  localparam logic [8:0] IDX_PTR_HIGH       = 9'h083;
  localparam logic [8:0] IDX_ENABLE_ONE     = 9'h0A8;
  localparam logic [8:0] IDX_PRIO_ONE       = 9'h0B8;
  localparam logic [8:0] IDX_STATUS_WORD    = 9'h0D0;
  localparam logic [8:0] IDX_ACCUM          = 9'h0E0;
  localparam logic [8:0] IDX_EXT_ENABLE_ONE = 9'h0E6;
  localparam logic [8:0] IDX_EXT_ENABLE_TWO = 9'h0E7;
  localparam logic [8:0] IDX_SECOND_ACC     = 9'h0F0;
  localparam logic [8:0] IDX_EXT_PRIO_ONE   = 9'h0F6;
  localparam logic [8:0] IDX_EXT_PRIO_TWO   = 9'h0F7;
  localparam logic [8:0] IDX_PEND_LOW       = 9'h100;
  localparam logic [8:0] IDX_PEND_HIGH      = 9'h101;
  localparam logic [8:0] IDX_SERVICE        = 9'h102;

  // Reset values and field positions
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam int         BIT_GLOBAL    = 7;
  localparam int         BANK_SHIFT    = 3;

  // Interrupt dispatch
  localparam int          NUM_SRC         = 16;
  localparam logic [15:0] AUTO_CLEAR_MASK = 16'h000F;
  localparam logic [15:0] VEC_BASE        = 16'h0003;
  localparam int          VEC_SHIFT       = 3;
  localparam logic [2:0]  CALL_CYCLES     = 3'h4;
  localparam logic [2:0]  CALL_PUSH_A     = 3'h3;
  localparam logic [2:0]  CALL_PUSH_B     = 3'h2;
  localparam logic [7:0]  RETURN_BYTES    = 8'h02;

  typedef enum logic [2:0] {ALU_NONE, ALU_ADD, ALU_ADD_WITH_CARRY, ALU_SUBTRACT_WITH_BORROW, ALU_MUL, ALU_DIV} alu_op_type;
  typedef enum logic [0:0] {ST_RUN, ST_CALL} dispatch_state_type;

  typedef struct packed {
    logic       carry_flag;
    logic       nibble_carry_flag;
    logic       user_flag_a;
    logic [1:0] bank_select;
    logic       overflow_flag;
    logic       user_flag_b;
    logic       parity_flag;
  } status_word_type;

  typedef struct packed {
    alu_op_type op;
    logic [7:0] operand;
  } alu_req_type;

  typedef struct packed {
    logic        busy;
    logic        level_high;
    logic [15:0] vector;
  } call_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } stack_write_type;

endpackage : core_ctrl_pkg
`default_nettype wire

/* File: test/peripheral_event_model.sv */
`timescale 1ns/1ps
`default_nettype none
module peripheral_event_model (
  // Clock
  input  wire logic        clk_in,
  // Bench commands, one bit per source
  input  wire logic [15:0] fire_in,
  // Event lines toward the core
  output logic      [15:0] irq_event_out
);
  // One-cycle fire gives an edge-style pulse; a held fire acts as a level source
  always_ff @(posedge clk_in) begin
    irq_event_out <= fire_in;
  end
endmodule : peripheral_event_model
`default_nettype wire

/* File: test/core_status_and_interrupt_dispatch_test.sv */
`timescale 1ns/1ps
`default_nettype none
module core_status_and_interrupt_dispatch_test;
  import core_ctrl_pkg::*;
  logic            clk_in;
  logic            srst_in;
  logic [10:0]     address;
  logic            rd;
  logic            wr;
  logic [31:0]     wdata;
  logic [3:0]      be;
  logic [31:0]     rdata;
  logic            waitreq;
  logic            done;
  logic            multi;
  logic            return_from_interrupt;
  logic            push;
  logic            pop;
  alu_req_type     alu;
  logic [15:0]     fire;
  logic [15:0]     irq;
  call_type        call;
  stack_write_type sw;
  logic [15:0]     iptr;
  logic [7:0]      bank;
  logic [7:0]      status;
  logic [31:0]     got;
  logic [7:0]      sw_last;
  int              sw_cnt;
  int              error_cnt;
  int              compares;

  peripheral_event_model events (.clk_in(clk_in), .fire_in(fire), .irq_event_out(irq));

  core_status_and_interrupt_dispatch dut (
    .clk_in(clk_in), .srst_in(srst_in), .avs_address_in(address), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .instr_done_in(done), .instr_multi_in(multi), .return_from_interrupt_in(return_from_interrupt),
    .push_in(push), .pop_in(pop), .alu_in(alu), .irq_event_in(irq), .call_out(call),
    .stack_write_out(sw), .indirect_pointer_out(iptr), .bank_base_out(bank), .status_word_out(status)
  );

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (sw.valid === 1'b1) begin
      sw_cnt++;
      sw_last = sw.addr;
    end
  end

  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Holds the request until waitrequest is seen low; the write lands and read data is taken there
  task automatic bus_go(input logic is_wr, input logic [8:0] idx, input logic [7:0] data);
    int n;
    n = 0;
    wr      <= is_wr;
    rd      <= ~is_wr;
    address <= {idx, 2'b00};
    wdata   <= {24'h000000, data};
    do begin
      @(posedge clk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0) begin
      error_cnt++;
      complete_run();
    end
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus_go

  // Idles after the transfer so outputs settle
  task automatic bus(input logic is_wr, input logic [8:0] idx, input logic [7:0] data);
    bus_go(is_wr, idx, data);
    repeat (3) @(posedge clk_in);
  endtask : bus

  task automatic rchk(input string name, input logic [8:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(name, {24'h000000, exp}, got);
  endtask : rchk

  task automatic alu_op(input alu_op_type op, input logic [7:0] operand);
    alu <= '{op: op, operand: operand};
    @(posedge clk_in);
    alu <= '{op: ALU_NONE, operand: 8'h00};
    repeat (2) @(posedge clk_in);
  endtask : alu_op

  task automatic fire_src(input int s);
    fire[s] <= 1'b1;
    @(posedge clk_in);
    fire <= 16'h0000;
    repeat (3) @(posedge clk_in);
  endtask : fire_src

  // One instruction boundary; a call starts the cycle after it
  task automatic step(input logic is_return_from_interrupt, input logic exp_busy);
    done <= 1'b1;
    return_from_interrupt <= is_return_from_interrupt;
    @(posedge clk_in);
    done <= 1'b0;
    return_from_interrupt <= 1'b0;
    repeat (2) @(posedge clk_in);
    check("call_busy", {31'h0, exp_busy}, {31'h0, call.busy});
  endtask : step

  initial begin
    srst_in = 1'b1;
    {rd, wr, done, multi, return_from_interrupt, push, pop} = 7'h00;
    address = 11'h000;
    wdata = 32'h00000000;
    be = 4'hF;
    alu = '{op: ALU_NONE, operand: 8'h00};
    fire = 16'h0000;
    sw_cnt = 0;
    error_cnt = 0;
    compares = 0;
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    rchk("stack_top", IDX_STACK_TOP, 8'h07);
    rchk("ptr_low", IDX_PTR_LOW, 8'h00);
    rchk("status", IDX_STATUS_WORD, 8'h00);
    bus(1'b1, 9'h0C7, 8'hFF);
    rchk("unmapped_c7", 9'h0C7, 8'h00);
    rchk("unmapped_b4", 9'h0B4, 8'h00);
    bus(1'b1, IDX_PTR_HIGH, 8'hA5);
    bus(1'b1, IDX_PTR_LOW, 8'h3C);
    check("pointer", 32'h0000A53C, {16'h0000, iptr});
    for (int b = 0; b < 4; b++) begin
      bus(1'b1, IDX_STATUS_WORD, 8'(b << 3));
      check("bank_base", 32'(b * 8), {24'h000000, bank});
    end
    bus(1'b1, IDX_ACCUM, 8'h07);
    check("parity", 32'h1, {31'h0, status[0]});
    bus(1'b1, IDX_STATUS_WORD, 8'h22);
    bus(1'b1, IDX_ACCUM, 8'h8F);
    alu_op(ALU_ADD, 8'h81);
    check("add_flags", 32'hE7, {24'h0, status});
    alu_op(ALU_ADD, 8'h01);
    check("add_clear", 32'h22, {24'h0, status});
    alu_op(ALU_SUBTRACT_WITH_BORROW, 8'h12);
    check("subtract_with_borrow_flags", 32'hE2, {24'h0, status});
    alu_op(ALU_ADD_WITH_CARRY, 8'h00);
    check("add_with_carry_flags", 32'hE2, {24'h0, status});
    bus(1'b1, IDX_ACCUM, 8'h10);
    bus(1'b1, IDX_SECOND_ACC, 8'h10);
    alu_op(ALU_MUL, 8'h00);
    check("mul_ov", 32'h1, {31'h0, status[2]});
    alu_op(ALU_DIV, 8'h00);
    check("div_ov", 32'h0, {31'h0, status[2]});
    bus(1'b1, IDX_SECOND_ACC, 8'h00);
    alu_op(ALU_DIV, 8'h00);
    check("div0_ov", 32'h1, {31'h0, status[2]});
    push <= 1'b1;
    @(posedge clk_in);
    push <= 1'b0;
    repeat (3) @(posedge clk_in);
    check("push_addr", 32'h08, {24'h0, sw_last});
    fire_src(5);
    rchk("pend_off", IDX_PEND_LOW, 8'h20);
    step(1'b0, 1'b0);
    bus(1'b1, IDX_ENABLE_ONE, 8'h20);
    step(1'b0, 1'b0);
    bus(1'b1, IDX_ENABLE_ONE, 8'hE0);
    step(1'b0, 1'b1);
    check("vector", 32'h002B, {16'h0, call.vector});
    check("level_low", 32'h0, {31'h0, call.level_high});
    repeat (4) @(posedge clk_in);
    check("push_pair", 32'h0A, {24'h0, sw_last});
    rchk("pend_kept", IDX_PEND_LOW, 8'h20);
    bus(1'b1, IDX_PRIO_ONE, 8'h40);
    fire_src(6);
    step(1'b0, 1'b1);
    check("vector_hi", 32'h0033, {16'h0, call.vector});
    check("level_high", 32'h1, {31'h0, call.level_high});
    repeat (4) @(posedge clk_in);
    step(1'b0, 1'b0);
    bus(1'b1, IDX_PEND_LOW, 8'h20);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b1);
    check("vector_again", 32'h002B, {16'h0, call.vector});
    repeat (4) @(posedge clk_in);
    bus(1'b1, IDX_PEND_LOW, 8'h00);
    step(1'b1, 1'b0);
    rchk("stack_ret", IDX_STACK_TOP, 8'h08);
    bus(1'b1, IDX_ENABLE_ONE, 8'h84);
    fire_src(2);
    step(1'b0, 1'b1);
    check("vector_src2", 32'h0013, {16'h0, call.vector});
    rchk("pend_auto", IDX_PEND_LOW, 8'h00);
    step(1'b1, 1'b0);
    fire_src(2);
    // Global enable drops on the edge before the boundary; a multi-cycle instruction holds it off
    bus_go(1'b1, IDX_ENABLE_ONE, 8'h04);
    multi <= 1'b1;
    step(1'b0, 1'b0);
    multi <= 1'b0;
    rchk("ea_off", IDX_ENABLE_ONE, 8'h04);
    bus(1'b1, IDX_ENABLE_ONE, 8'h84);
    bus_go(1'b1, IDX_ENABLE_ONE, 8'h04);
    step(1'b0, 1'b1);
    check("vector_ea", 32'h0013, {16'h0, call.vector});
    rchk("pend_ea", IDX_PEND_LOW, 8'h00);
    check("push_count", 32'h0000000B, sw_cnt);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    complete_run();
  end
endmodule : core_status_and_interrupt_dispatch_test
`default_nettype wire
